// ===== hdl/wwdt_pkg.sv
//
// Contract
// - An active watchdog that is not cleared before its time-out expires requests a device reset.
// - The time base is the low, mid or secondary oscillator, chosen by config or runtime select.
// - Mode 11 keeps the watchdog active always, Sleep included, ignoring the software enable.
// - Mode 10 keeps it active while awake and disabled in Sleep, ignoring the software enable.
// - Mode 01 makes it follow the software enable bit, awake and in Sleep alike.
// - Mode 00 keeps it disabled in every state.
// - The period select sets 1 ms to 256 s nominal, with a 2 s default after reset.
// - In windowed mode a clear outside the open window is a violation that resets like a time-out.
// - Window size comes from the config field, or from the runtime field when config is 111.
// - The open window spans 12.5 to 100 percent of the period.
// - A violation resets and clears the active-low violation flag; reset or a firmware write sets it.
// - The counter clears on reset, valid clear, Sleep entry and exit, disable and oscillator start-up.
// - Any software write to either control register clears the counter.
// - In windowed mode a read of the first control register arms the clear; unarmed is a violation.
// - A time-out in Sleep wakes the device and updates status instead of resetting.
// - Period code 0 is 1:32, each step doubles, up to 1:8388608; code 01011 is the 2 s default.
package wwdt_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL_FIRST = 8'h00;
    localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
    localparam logic [7:0] ADDR_POWER = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam int SWEN_BIT = 0;
    localparam int PS_LSB = 1;
    localparam int CS_LSB = 4;
    localparam int WIN_LSB = 0;
    localparam int WV_N_BIT = 0;
    localparam int TO_N_BIT = 1;
    localparam int WAKE_BIT = 2;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_VIOLATION = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_W = 3;
    localparam int CNT_W = 24;
    localparam logic [4:0] PS_DEFAULT = 5'h0B;
    localparam logic [4:0] PS_CFG_RW = 5'h1F;
    localparam logic [4:0] PS_MAX = 5'h12;
    localparam logic [23:0] PRESCALE_BASE = 24'h000020;
    localparam logic [2:0] SEL_CFG_RW = 3'h7;
    localparam logic [2:0] WIN_FULL = 3'h7;
    localparam logic [2:0] CS_DEFAULT = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0]
    {
        MODE_OFF = 2'b00,
        MODE_SW = 2'b01,
        MODE_AWAKE = 2'b10,
        MODE_ON = 2'b11
    } wwdt_mode_type;
endpackage

// ===== hdl/wwdt_top.sv
`timescale 1ns/10ps
module wwdt_top
    import wwdt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] wd_mode_cfg,
    input wire logic [2:0] cfg_wd_clock_select,
    input wire logic [2:0] cfg_window_select,
    input wire logic [4:0] cfg_period_select,
    input wire logic low_freq_internal_osc,
    input wire logic mid_freq_internal_osc,
    input wire logic secondary_osc,
    input wire logic sleep_mode,
    input wire logic osc_startup_timer,
    input wire logic watchdog_clear_instr,
    output logic wd_reset_req,
    output logic wd_wake,
    output logic irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic known_addr(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        known_addr = (w == ADDR_CTRL_FIRST) || (w == ADDR_CTRL_SECOND) ||
            (w == ADDR_POWER) || (w == ADDR_IRQ_STATUS) ||
            (w == ADDR_IRQ_MASK) || (w == ADDR_COUNT);
    endfunction

    function automatic logic [23:0] closed_len(input logic [23:0] lim, input logic [2:0] win);
        logic [26:0] prod;
        prod = {3'h0, lim} * {24'h000000, WIN_FULL - win};
        closed_len = prod[26:3];
    endfunction

    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg, aw_held_reg, w_held_reg;
    logic swen_reg, armed_reg, sleep_d_reg;
    logic wv_n_reg, to_n_reg, wake_flag_reg;
    logic [4:0] ps_reg;
    logic [2:0] cs_reg, win_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
    logic [CNT_W-1:0] count_reg;
    logic [2:0] osc_s1_reg, osc_s2_reg, osc_s3_reg;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic wr_fire, rd_fire, wr_en, wr_ctrl;
    logic [7:0] wr_word;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wr_word = {awaddr_reg[7:2], 2'b00};
    assign wr_en = wr_fire && wstrb0_reg;
    // Counter clears on any control write, whatever the strobes say
    assign wr_ctrl = wr_fire && (wr_word == ADDR_CTRL_FIRST || wr_word == ADDR_CTRL_SECOND);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            s_axi_awready <= 1'b1;
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_wready <= 1'b1;
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb0_reg <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb0_reg <= s_axi_wstrb[0];
        end
        else if (wr_fire)
        begin
            s_axi_wready <= 1'b1;
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_addr(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
                ADDR_CTRL_FIRST: s_axi_rdata <= {26'h0, ps_reg, swen_reg};
                ADDR_CTRL_SECOND: s_axi_rdata <= {25'h0, cs_reg, 1'b0, win_reg};
                ADDR_POWER: s_axi_rdata <= {29'h0, wake_flag_reg, to_n_reg, wv_n_reg};
                ADDR_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_stat_reg};
                ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_reg};
                ADDR_COUNT: s_axi_rdata <= {8'h00, count_reg};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Period, clock and window fields are writable only when the matching config field is all ones
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ps_reg <= (cfg_period_select == PS_CFG_RW) ? PS_DEFAULT : cfg_period_select;
            cs_reg <= (cfg_wd_clock_select == SEL_CFG_RW) ? CS_DEFAULT : cfg_wd_clock_select;
            win_reg <= cfg_window_select;
            swen_reg <= 1'b0;
            irq_mask_reg <= MASK_RESET;
        end
        else if (wr_en)
        begin
            if (wr_word == ADDR_CTRL_FIRST)
            begin
                swen_reg <= wdata_reg[SWEN_BIT];
                if (cfg_period_select == PS_CFG_RW)
                    ps_reg <= wdata_reg[PS_LSB +: 5];
            end
            if (wr_word == ADDR_CTRL_SECOND)
            begin
                if (cfg_wd_clock_select == SEL_CFG_RW)
                    cs_reg <= wdata_reg[CS_LSB +: 3];
                if (cfg_window_select == SEL_CFG_RW)
                    win_reg <= wdata_reg[WIN_LSB +: 3];
            end
            if (wr_word == ADDR_IRQ_MASK)
                irq_mask_reg <= wdata_reg[IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    logic [2:0] osc_tick;
    logic tick;
    wwdt_mode_type mode;
    assign mode = wwdt_mode_type'(wd_mode_cfg);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_osc
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    osc_s1_reg[gi] <= 1'b0;
                    osc_s2_reg[gi] <= 1'b0;
                    osc_s3_reg[gi] <= 1'b0;
                end
                else
                begin
                    osc_s1_reg[gi] <= (gi == 0) ? low_freq_internal_osc :
                        (gi == 1) ? mid_freq_internal_osc : secondary_osc;
                    osc_s2_reg[gi] <= osc_s1_reg[gi];
                    osc_s3_reg[gi] <= osc_s2_reg[gi];
                end
            end
            // Edge taken past the synchroniser so the first stage stays clean
            assign osc_tick[gi] = osc_s2_reg[gi] && !osc_s3_reg[gi];
        end
    endgenerate

    logic [2:0] cs_eff, win_eff;
    logic [4:0] ps_eff;
    logic [23:0] limit, closed;
    // Reserved selects give no tick, so the counter simply stalls
    assign cs_eff = (cfg_wd_clock_select == SEL_CFG_RW) ? cs_reg : cfg_wd_clock_select;
    assign tick = (cs_eff < 3'h3) ? osc_tick[cs_eff[1:0]] : 1'b0;
    assign ps_eff = (ps_reg > PS_MAX) ? PS_MAX : ps_reg;
    assign limit = PRESCALE_BASE << ps_eff;
    assign win_eff = (cfg_window_select == SEL_CFG_RW) ? win_reg : cfg_window_select;
    assign closed = closed_len(limit, win_eff);

    // ----------------------------------------
    // Watchdog core
    // ----------------------------------------
    logic active, windowed, violation, valid_clear, expire, clr_cnt;
    always_comb
    begin
        case (mode)
            MODE_ON: active = 1'b1;
            MODE_AWAKE: active = !sleep_mode;
            MODE_SW: active = swen_reg;
            MODE_OFF: active = 1'b0;
            default: active = 1'b0;
        endcase
    end

    assign windowed = (win_eff != WIN_FULL);
    assign violation = watchdog_clear_instr && active && windowed &&
        (!armed_reg || count_reg < closed);
    assign valid_clear = watchdog_clear_instr && active && !violation;
    assign expire = active && tick && (count_reg == limit - 24'h000001);
    assign clr_cnt = !active || valid_clear || (sleep_mode != sleep_d_reg) ||
        osc_startup_timer || wr_ctrl || expire || violation;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_reg <= 24'h000000;
        else if (clr_cnt)
            count_reg <= 24'h000000;
        else if (tick)
            count_reg <= count_reg + 24'h000001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sleep_d_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else
        begin
            sleep_d_reg <= sleep_mode;
            if (watchdog_clear_instr)
                armed_reg <= 1'b0;
            else if (rd_fire && {s_axi_araddr[7:2], 2'b00} == ADDR_CTRL_FIRST)
                armed_reg <= 1'b1;
        end
    end

    // A violation always resets; only a plain time-out is softened by Sleep
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wd_reset_req <= 1'b0;
            wd_wake <= 1'b0;
        end
        else
        begin
            wd_reset_req <= violation || (expire && !sleep_mode);
            wd_wake <= expire && sleep_mode && !violation;
        end
    end

    // Hardware events beat a same-cycle firmware write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wv_n_reg <= 1'b1;
            to_n_reg <= 1'b1;
            wake_flag_reg <= 1'b0;
        end
        else
        begin
            if (violation)
                wv_n_reg <= 1'b0;
            else if (wr_en && wr_word == ADDR_POWER && wdata_reg[WV_N_BIT])
                wv_n_reg <= 1'b1;
            if (expire)
                to_n_reg <= 1'b0;
            else if (wr_en && wr_word == ADDR_POWER && wdata_reg[TO_N_BIT])
                to_n_reg <= 1'b1;
            if (expire && sleep_mode)
                wake_flag_reg <= 1'b1;
            else if (wr_en && wr_word == ADDR_POWER && wdata_reg[WAKE_BIT])
                wake_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    logic [IRQ_W-1:0] irq_evt, irq_w1c;
    assign irq_evt = {expire && sleep_mode, violation, expire};
    assign irq_w1c = (wr_en && wr_word == ADDR_IRQ_STATUS) ? wdata_reg[IRQ_W-1:0] : 3'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_reg <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_evt;
            irq <= |(((irq_stat_reg & ~irq_w1c) | irq_evt) & irq_mask_reg);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_closed_clear;
        watchdog_clear_instr && active && windowed && armed_reg && count_reg < closed;
    endsequence
    sequence s_reset_flagged;
        wd_reset_req && !wv_n_reg;
    endsequence

    property p_timeout_reset;
        active && tick && count_reg == limit - 24'h000001 && !sleep_mode |=> wd_reset_req;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("missed time-out reset");

    property p_always_on;
        wd_mode_cfg == 2'b11 |-> active;
    endproperty
    a_always_on: assert property (p_always_on) else $error("mode 11 not active");

    property p_off_in_sleep;
        wd_mode_cfg == 2'b10 && sleep_mode [*2] |-> count_reg == 24'h000000;
    endproperty
    a_off_in_sleep: assert property (p_off_in_sleep) else $error("mode 10 counts in sleep");

    property p_sw_off;
        wd_mode_cfg == 2'b01 && !swen_reg |=> count_reg == 24'h000000 && !wd_reset_req;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("sw disabled yet running");

    property p_mode_off;
        wd_mode_cfg == 2'b00 |=> !wd_reset_req && !wd_wake;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode 00 fired");

    property p_closed_violation;
        s_closed_clear |=> s_reset_flagged;
    endproperty
    a_closed_violation: assert property (p_closed_violation) else $error("early clear kept");

    property p_unarmed;
        watchdog_clear_instr && active && windowed && !armed_reg |=> wd_reset_req;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("unarmed clear accepted");

    property p_ctrl_write_clears;
        wr_ctrl |=> count_reg == 24'h000000;
    endproperty
    a_ctrl_write_clears: assert property (p_ctrl_write_clears) else $error("write kept count");

    property p_sleep_wake;
        expire && sleep_mode && !violation |=> wd_wake && !wd_reset_req && !to_n_reg;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep time-out misbehaved");

    property p_flag_held;
        s_reset_flagged ##0 !(wr_en && wr_word == ADDR_POWER) |=> !wv_n_reg;
    endproperty
    a_flag_held: assert property (p_flag_held) else $error("violation flag lost");
endmodule

// ===== testbench/wwdt_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module wwdt_tb_top
    import wwdt_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk, aresetn;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, wd_mode_cfg, rsp;
    logic [2:0] cfg_wd_clock_select, cfg_window_select, osc;
    logic [4:0] cfg_period_select;
    logic sleep_mode, osc_startup_timer, watchdog_clear_instr, wd_reset_req, wd_wake, irq;
    int failures, check_count, cycles, rst_cnt, wake_cnt, r0, w0;
    logic [5:0] e;
    // Mode table entries: mode, sw enable, sleep, reset pulses, wake pulses
    localparam logic [5:0] MODE_TAB [8] = '{6'h00, 6'h08, 6'h10, 6'h1A, 6'h1D, 6'h22, 6'h24, 6'h35};

    // ----------------------------------------
    // Design
    // ----------------------------------------
    wwdt_top dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wd_mode_cfg(wd_mode_cfg),
        .cfg_wd_clock_select(cfg_wd_clock_select), .cfg_window_select(cfg_window_select),
        .cfg_period_select(cfg_period_select), .low_freq_internal_osc(osc[0]),
        .mid_freq_internal_osc(osc[1]), .secondary_osc(osc[2]), .sleep_mode(sleep_mode),
        .osc_startup_timer(osc_startup_timer), .watchdog_clear_instr(watchdog_clear_instr),
        .wd_reset_req(wd_reset_req), .wd_wake(wd_wake), .irq(irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Pulse counters add one for every cycle an output stands high, so a longer pulse counts more than once
    always @(posedge aclk)
    begin
        cycles++;
        if (wd_reset_req === 1'b1) rst_cnt++;
        if (wd_wake === 1'b1) wake_cnt++;
        if (cycles == 40000)
        begin
            $display("[FAIL] cycles expected below 40000 seen %0d", cycles);
            failures++;
            conclude();
        end
    end

    // ----------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 50);
        `CHK("bvalid", 1'b1, s_axi_bvalid)
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end
        while (s_axi_rvalid !== 1'b1 && n < 50);
        `CHK("rvalid", 1'b1, s_axi_rvalid)
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Slow clocks are far slower than aclk; two cycles high and three low per tick keeps the sync happy
    task automatic tick(input logic [2:0] m, input int n);
        repeat (n)
        begin
            @(posedge aclk);
            osc <= m;
            repeat (2) @(posedge aclk);
            osc <= 3'h0;
            repeat (2) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask

    task automatic clr();
        @(posedge aclk);
        watchdog_clear_instr <= 1'b1;
        @(posedge aclk);
        watchdog_clear_instr <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    task automatic t_reset_values();
        rd_reg(ADDR_CTRL_FIRST);
        `CHK("ctrl_first", 32'h00000016, rd)
        rd_reg(ADDR_CTRL_SECOND);
        `CHK("ctrl_second", 32'h00000007, rd)
        rd_reg(ADDR_POWER);
        `CHK("power", 32'h00000003, rd)
        rd_reg(ADDR_IRQ_MASK);
        `CHK("mask", 32'h00000000, rd)
        rd_reg(8'h1C);
        `CHK("unmapped rresp", RESP_SLVERR, rsp)
        wr(8'h1C, 32'h00000000);
        `CHK("unmapped bresp", RESP_SLVERR, rsp)
        $display("test reset_values done");
    endtask

    task automatic t_timeout();
        wr(ADDR_CTRL_FIRST, 32'h00000000);
        r0 = rst_cnt;
        tick(3'h1, 20);
        rd_reg(ADDR_COUNT);
        `CHK("count", 32'h00000014, rd)
        s_axi_wstrb <= 4'h0;
        wr(ADDR_CTRL_FIRST, 32'h00000001);
        s_axi_wstrb <= 4'hF;
        rd_reg(ADDR_CTRL_FIRST);
        `CHK("strobe off write", 32'h00000000, rd)
        tick(3'h1, 31);
        `CHK("no early timeout", 0, rst_cnt - r0)
        tick(3'h1, 1);
        `CHK("timeout pulse", 1, rst_cnt - r0)
        rd_reg(ADDR_POWER);
        `CHK("timeout flag", 32'h00000001, rd)
        rd_reg(ADDR_IRQ_STATUS);
        `CHK("irq status", 32'h00000001, rd)
        `CHK("irq masked", 1'b0, irq)
        wr(ADDR_IRQ_MASK, 32'h00000001);
        repeat (2) @(posedge aclk);
        `CHK("irq raised", 1'b1, irq)
        wr(ADDR_IRQ_STATUS, 32'h00000001);
        repeat (2) @(posedge aclk);
        `CHK("irq cleared", 1'b0, irq)
        wr(ADDR_POWER, 32'h00000003);
        rd_reg(ADDR_POWER);
        `CHK("power restored", 32'h00000003, rd)
        $display("test timeout done");
    endtask

    task automatic t_clock_select();
        for (int s = 0; s < 4; s++)
        begin
            wr(ADDR_CTRL_SECOND, 32'(16 * s + 7));
            wr(ADDR_CTRL_FIRST, 32'h00000000);
            r0 = rst_cnt;
            tick(~(3'h1 << s), 40);
            `CHK("other sources", 0, rst_cnt - r0)
            tick(3'h1 << s, 32);
            `CHK("chosen source", (s < 3) ? 1 : 0, rst_cnt - r0)
        end
        wr(ADDR_CTRL_SECOND, 32'h00000007);
        $display("test clock_select done");
    endtask

    task automatic t_modes();
        for (int i = 0; i < 8; i++)
        begin
            e = MODE_TAB[i];
            wd_mode_cfg <= e[5:4];
            sleep_mode <= e[2];
            wr(ADDR_CTRL_FIRST, {31'h0, e[3]});
            r0 = rst_cnt;
            w0 = wake_cnt;
            tick(3'h1, 32);
            `CHK("mode reset", e[1], rst_cnt - r0)
            `CHK("mode wake", e[0], wake_cnt - w0)
        end
        rd_reg(ADDR_POWER);
        `CHK("wake flags", 32'h00000005, rd)
        sleep_mode <= 1'b0;
        wd_mode_cfg <= MODE_ON;
        wr(ADDR_POWER, 32'h00000007);
        $display("test modes done");
    endtask

    task automatic t_clears();
        wr(ADDR_CTRL_FIRST, 32'h00000000);
        r0 = rst_cnt;
        w0 = wake_cnt;
        tick(3'h1, 20);
        sleep_mode <= 1'b1;
        tick(3'h1, 20);
        sleep_mode <= 1'b0;
        tick(3'h1, 20);
        osc_startup_timer <= 1'b1;
        tick(3'h1, 40);
        rd_reg(ADDR_COUNT);
        `CHK("held by start-up", 32'h00000000, rd)
        osc_startup_timer <= 1'b0;
        tick(3'h1, 20);
        wd_mode_cfg <= MODE_OFF;
        @(posedge aclk);
        wd_mode_cfg <= MODE_ON;
        tick(3'h1, 20);
        `CHK("clears reset", 0, rst_cnt - r0)
        `CHK("clears wake", 0, wake_cnt - w0)
        $display("test clears done");
    endtask

    // Half window: closed for the first 16 of 32 ticks
    task automatic t_window();
        cfg_window_select <= 3'h3;
        do_reset();
        wr(ADDR_CTRL_FIRST, 32'h00000000);
        wr(ADDR_CTRL_SECOND, 32'h00000007);
        rd_reg(ADDR_CTRL_SECOND);
        `CHK("window read-only", 32'h00000003, rd)
        r0 = rst_cnt;
        tick(3'h1, 15);
        rd_reg(ADDR_CTRL_FIRST);
        clr();
        `CHK("early clear", 1, rst_cnt - r0)
        rd_reg(ADDR_POWER);
        `CHK("violation flag", 32'h00000002, rd)
        wr(ADDR_POWER, 32'h00000003);
        rd_reg(ADDR_POWER);
        `CHK("flag set back", 32'h00000003, rd)
        tick(3'h1, 16);
        clr();
        `CHK("unarmed clear", 2, rst_cnt - r0)
        tick(3'h1, 16);
        rd_reg(ADDR_CTRL_FIRST);
        clr();
        `CHK("armed clear", 2, rst_cnt - r0)
        tick(3'h1, 31);
        `CHK("clear restarts", 2, rst_cnt - r0)
        tick(3'h1, 1);
        `CHK("windowed timeout", 3, rst_cnt - r0)
        cfg_window_select <= 3'h7;
        do_reset();
        $display("test window done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        wd_mode_cfg = MODE_ON;
        cfg_wd_clock_select = 3'h7;
        cfg_window_select = 3'h7;
        cfg_period_select = 5'h1F;
        osc = 3'h0;
        {sleep_mode, osc_startup_timer, watchdog_clear_instr} = 3'h0;
        do_reset();
        t_reset_values();
        t_timeout();
        t_clock_select();
        t_modes();
        t_clears();
        t_window();
        conclude();
    end
endmodule
